// File: design/vdo_output_ctrl.sv
// standard autoswitch, sync timing and pixel output formatter
`timescale 1ns/1ps
module vdo_output_ctrl
  import vdo_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic          i_rst,
  input  wire logic [7:0]    i_reg_addr,
  input  wire logic          i_reg_wr,
  input  wire logic [7:0]    i_reg_wdata,
  input  wire logic          i_reg_rd,
  output logic      [7:0]    o_reg_rdata,
  input  wire logic          i_line_clk,
  input  wire logic          i_sample_valid,
  input  wire vdo_pixel_type i_sample,
  input  wire logic          i_std_detect,
  input  wire vdo_std_type   i_std_code,
  input  wire logic          i_signal_present,
  input  wire logic          i_slice_valid,
  input  wire logic [9:0]    i_slice_data,
  input  wire vdo_pixel_type i_overlay_pixel,
  input  wire logic          i_overlay_fast_switch_in,
  input  wire logic          i_scart_fast_switch_in,
  output vdo_std_type        o_active_std,
  output logic               o_locked,
  output logic               o_filter_bypass,
  output logic               o_sync_on_luma,
  output logic               o_scart_rgb_sel,
  output logic [19:0]        o_pixel_data,
  output vdo_sync_type       o_sync,
  output logic               o_pixel_clock_out,
  output logic               o_data_oe,
  output logic               o_clk_oe
);
  `include "vdo_consts.svh"

  function automatic logic [9:0] sync_word(input logic f, input logic v, input logic h);
    sync_word = {1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00};
  endfunction : sync_word

  function automatic logic is_525(input vdo_std_type s);
    is_525 = (s == VDO_STD_NTSC_M) || (s == VDO_STD_PAL_M) || (s == VDO_STD_NTSC_443);
  endfunction : is_525

  // ----------------------------------------
  // registers
  // ----------------------------------------
  vdo_input_type input_sel_r;
  logic [7:0]    std_mask_r;
  logic [7:0]    fmt_ctrl_r;
  logic [15:0]   av_beg_r;
  logic [15:0]   av_end_r;
  logic [15:0]   vs_beg_r;
  logic [15:0]   vs_end_r;
  logic [7:0]    range_ctrl_r;
  logic [7:0]    drive_en_r;
  logic          input_chg;
  vdo_fmt_type   fmt;

  assign input_chg = i_reg_wr && (i_reg_addr == `VDO_REG_INPUT_SEL)
                     && (vdo_input_type'(i_reg_wdata[1:0]) != input_sel_r);
  // code 3 has no enum member, so it is folded onto discrete sync
  assign fmt = (fmt_ctrl_r[1:0] == 2'h3) ? VDO_FMT_DISCRETE : vdo_fmt_type'(fmt_ctrl_r[1:0]);

  // only a hardware reset restores the default exclusions
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      input_sel_r  <= VDO_IN_COMPOSITE;
      std_mask_r   <= `VDO_RST_STD_MASK;
      fmt_ctrl_r   <= 8'h00;
      av_beg_r     <= `VDO_RST_AV_BEG;
      av_end_r     <= `VDO_RST_AV_END;
      vs_beg_r     <= `VDO_RST_VS_BEG;
      vs_end_r     <= `VDO_RST_VS_END;
      range_ctrl_r <= `VDO_RST_RANGE_CTRL;
      drive_en_r   <= `VDO_RST_DRIVE_EN;
    end else if (i_reg_wr) begin
      unique case (i_reg_addr)
        `VDO_REG_INPUT_SEL:  input_sel_r <= vdo_input_type'(i_reg_wdata[1:0]);
        `VDO_REG_STD_MASK:   std_mask_r <= i_reg_wdata;
        `VDO_REG_FMT_CTRL:   fmt_ctrl_r <= i_reg_wdata;
        `VDO_REG_AV_BEG_LO:  av_beg_r[7:0] <= i_reg_wdata;
        `VDO_REG_AV_BEG_HI:  av_beg_r[15:8] <= i_reg_wdata;
        `VDO_REG_AV_END_LO:  av_end_r[7:0] <= i_reg_wdata;
        `VDO_REG_AV_END_HI:  av_end_r[15:8] <= i_reg_wdata;
        `VDO_REG_VS_BEG_LO:  vs_beg_r[7:0] <= i_reg_wdata;
        `VDO_REG_VS_BEG_HI:  vs_beg_r[15:8] <= i_reg_wdata;
        `VDO_REG_VS_END_LO:  vs_end_r[7:0] <= i_reg_wdata;
        `VDO_REG_VS_END_HI:  vs_end_r[15:8] <= i_reg_wdata;
        `VDO_REG_RANGE_CTRL: range_ctrl_r <= i_reg_wdata;
        `VDO_REG_DRIVE_EN:   drive_en_r <= i_reg_wdata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // pin synchronisers and pixel tick
  // ----------------------------------------
  logic [2:0] lclk_r;
  logic [1:0] sig_r;
  logic [1:0] ovl_r;
  logic [1:0] scart_r;
  logic       tick;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      lclk_r  <= 3'h0;
      sig_r   <= 2'h0;
      ovl_r   <= 2'h0;
      scart_r <= 2'h0;
    end else begin
      lclk_r  <= {lclk_r[1:0], i_line_clk};
      sig_r   <= {sig_r[0], i_signal_present};
      ovl_r   <= {ovl_r[0], i_overlay_fast_switch_in};
      scart_r <= {scart_r[0], i_scart_fast_switch_in};
    end
  end
  assign tick = lclk_r[1] & ~lclk_r[2];

  // ----------------------------------------
  // autoswitch and lock
  // ----------------------------------------
  vdo_std_type std_r;
  logic [3:0]  field_cnt_r;
  logic        field_evt;

  // a masked standard is ignored and the last accepted one is kept
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      std_r <= VDO_STD_NTSC_M;
    end else if (i_std_detect && std_mask_r[i_std_code]) begin
      std_r <= i_std_code;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || input_chg) begin
      field_cnt_r <= 4'h0;
    end else if (field_evt && field_cnt_r != `VDO_LOCK_FIELDS) begin
      field_cnt_r <= field_cnt_r + 4'h1;
    end
  end

  assign o_active_std    = std_r;
  assign o_locked        = (field_cnt_r == `VDO_LOCK_FIELDS) && sig_r[1];
  assign o_filter_bypass = (input_sel_r == VDO_IN_COMPONENT);
  // the decoder only handles SD, so component always qualifies
  assign o_sync_on_luma  = (input_sel_r == VDO_IN_COMPONENT);
  assign o_scart_rgb_sel = (input_sel_r == VDO_IN_SCART) && scart_r[1];

  // ----------------------------------------
  // decimation
  // ----------------------------------------
  logic          smp_ph_r;
  vdo_pixel_type first_r;
  vdo_pixel_type dec_r;
  vdo_pixel_type raw_a_r;
  vdo_pixel_type raw_b_r;
  logic [10:0]   sum_y;
  logic [10:0]   sum_c;

  assign sum_y = {1'b0, first_r.luma} + {1'b0, i_sample.luma};
  assign sum_c = {1'b0, first_r.chroma} + {1'b0, i_sample.chroma};

  // decimation stays in the path for every input, component included
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      smp_ph_r <= 1'b0;
      first_r  <= '0;
      dec_r    <= '0;
      raw_a_r  <= '0;
      raw_b_r  <= '0;
    end else if (i_sample_valid) begin
      smp_ph_r <= ~smp_ph_r;
      if (!smp_ph_r) begin
        first_r <= i_sample;
      end else begin
        dec_r   <= '{luma: sum_y[10:1], chroma: sum_c[10:1]};
        raw_a_r <= first_r;
        raw_b_r <= i_sample;
      end
    end
  end

  // ----------------------------------------
  // sync timing
  // ----------------------------------------
  logic [9:0] h_r;
  logic [9:0] v_r;
  logic       wph_r;
  logic [9:0] h_total;
  logic [9:0] v_total;
  logic [9:0] v_half;
  logic [9:0] v_in_field;
  logic [9:0] vbl_lines;
  logic       pix_step;
  logic       line_end;
  logic       hblank;
  logic       vblank;
  logic       field;
  logic       vs_win;
  logic       av_win;

  assign h_total   = is_525(std_r) ? `VDO_H_TOTAL_525 : `VDO_H_TOTAL_625;
  assign v_total   = is_525(std_r) ? `VDO_LINES_525 : `VDO_LINES_625;
  assign vbl_lines = is_525(std_r) ? `VDO_VBL_LINES_525 : `VDO_VBL_LINES_625;
  assign v_half    = {1'b0, v_total[9:1]};
  assign field     = (v_r >= v_half);
  assign v_in_field = field ? v_r - v_half : v_r;
  // one bus words interleave chroma and luma, so a pixel takes two ticks
  assign pix_step  = tick && (fmt == VDO_FMT_WIDE || wph_r);
  assign line_end  = (h_r == h_total - 10'h001);
  assign hblank    = (h_r < `VDO_H_ACT_BEG) || (h_r >= `VDO_H_ACT_END);
  assign vblank    = (v_in_field < vbl_lines);
  assign vs_win    = ({6'h00, v_in_field} >= vs_beg_r) && ({6'h00, v_in_field} < vs_end_r);
  assign av_win    = ({6'h00, h_r} >= av_beg_r) && ({6'h00, h_r} < av_end_r);
  assign field_evt = pix_step && line_end && ((v_r == v_total - 10'h001) || (v_r == v_half - 10'h001));

  // timing keeps running on the last standard when the input goes quiet
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      h_r   <= 10'h000;
      v_r   <= 10'h000;
      wph_r <= 1'b0;
    end else if (tick) begin
      wph_r <= (fmt == VDO_FMT_WIDE) ? 1'b0 : ~wph_r;
      if (pix_step) begin
        h_r <= line_end ? 10'h000 : h_r + 10'h001;
        if (line_end) begin
          v_r <= (v_r >= v_total - 10'h001) ? 10'h000 : v_r + 10'h001;
        end
      end
    end
  end

  // ----------------------------------------
  // pixel selection
  // ----------------------------------------
  vdo_pixel_type src;
  vdo_pixel_type clamped;
  logic [9:0]    word_1bus;
  logic          code_slot;
  logic [1:0]    code_idx;
  logic [9:0]    code_word;
  logic          ext;

  assign ext = range_ctrl_r[`VDO_BIT_EXT_RANGE];

  always_comb begin
    src = sig_r[1] ? dec_r : '{luma: `VDO_BLACK_Y, chroma: `VDO_BLACK_C};
    if (sig_r[1] && ovl_r[1]) begin
      src = i_overlay_pixel;
    end
    if (hblank || !sig_r[1]) begin
      src = '{luma: `VDO_BLACK_Y, chroma: `VDO_BLACK_C};
    end else if (vblank) begin
      if (fmt_ctrl_r[`VDO_BIT_RAW_VBI]) begin
        src = wph_r ? raw_b_r : raw_a_r;
      end else if (fmt_ctrl_r[`VDO_BIT_SLICED_VBI] && i_slice_valid) begin
        src = '{luma: i_slice_data, chroma: i_slice_data};
      end
    end else if (fmt_ctrl_r[`VDO_BIT_FULL_FIELD] && i_slice_valid) begin
      src = '{luma: i_slice_data, chroma: i_slice_data};
    end
    if (!av_win) begin
      src = '{luma: `VDO_BLACK_Y, chroma: `VDO_BLACK_C};
    end
    if (fmt != VDO_FMT_EMBEDDED && vs_win) begin
      src = '{luma: `VDO_BLACK_Y, chroma: `VDO_BLACK_C};
    end
  end

  localparam logic [9:0] CLAMP_MAX [2] = '{`VDO_STD_MAX_Y, `VDO_STD_MAX_C};
  logic [9:0] ch_in  [2];
  logic [9:0] ch_out [2];
  assign ch_in[0] = src.luma;
  assign ch_in[1] = src.chroma;

  for (genvar g = 0; g < 2; g++) begin : g_clamp
    vdo_range_clamp #(
      .STD_MAX (CLAMP_MAX[g])
    ) u_clamp (
      .i_data (ch_in[g]),
      .i_ext  (ext),
      .o_data (ch_out[g])
    );
  end
  assign clamped = '{luma: ch_out[0], chroma: ch_out[1]};

  // timing codes sit in the two pixels just before and after active video
  always_comb begin
    code_slot = 1'b0;
    code_idx  = {1'b0, wph_r};
    if (h_r == `VDO_H_ACT_BEG - 10'h002 || h_r == `VDO_H_ACT_END) begin
      code_slot = 1'b1;
    end else if (h_r == `VDO_H_ACT_BEG - 10'h001 || h_r == `VDO_H_ACT_END + 10'h001) begin
      code_slot = 1'b1;
      code_idx  = {1'b1, wph_r};
    end
    unique case (code_idx)
      2'h0: code_word = `VDO_CODE_PRE;
      2'h1: code_word = `VDO_CODE_ZERO;
      2'h2: code_word = `VDO_CODE_ZERO;
      2'h3: code_word = sync_word(field, vblank, h_r >= `VDO_H_ACT_END);
    endcase
    word_1bus = wph_r ? clamped.luma : clamped.chroma;
    if (fmt == VDO_FMT_EMBEDDED && code_slot) begin
      word_1bus = code_word;
    end
  end

  // ----------------------------------------
  // output launch
  // ----------------------------------------
  // data and sync pins are launched on the same tick so the backend samples one edge
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pixel_data <= 20'h00000;
      o_sync       <= '0;
    end else if (tick) begin
      if (!drive_en_r[`VDO_BIT_DATA_OE]) begin
        o_pixel_data <= 20'h00000;
      end else if (fmt == VDO_FMT_WIDE) begin
        o_pixel_data <= {clamped.luma, clamped.chroma};
      end else begin
        o_pixel_data <= {10'h000, word_1bus};
      end
      o_sync.hsync  <= (h_r < `VDO_HS_WIDTH);
      o_sync.vsync  <= vs_win;
      o_sync.field  <= field;
      o_sync.active <= av_win;
    end
  end

  assign o_data_oe = drive_en_r[`VDO_BIT_DATA_OE];
  assign o_clk_oe  = drive_en_r[`VDO_BIT_CLK_OE];
  // the sampled link clock is echoed so its rise matches the data launch
  assign o_pixel_clock_out = lclk_r[2] & drive_en_r[`VDO_BIT_CLK_OE];

  // ----------------------------------------
  // register read
  // ----------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      unique case (i_reg_addr)
        `VDO_REG_INPUT_SEL:  o_reg_rdata <= {6'h00, input_sel_r};
        `VDO_REG_STD_MASK:   o_reg_rdata <= std_mask_r;
        `VDO_REG_FMT_CTRL:   o_reg_rdata <= fmt_ctrl_r;
        `VDO_REG_AV_BEG_LO:  o_reg_rdata <= av_beg_r[7:0];
        `VDO_REG_AV_BEG_HI:  o_reg_rdata <= av_beg_r[15:8];
        `VDO_REG_AV_END_LO:  o_reg_rdata <= av_end_r[7:0];
        `VDO_REG_AV_END_HI:  o_reg_rdata <= av_end_r[15:8];
        `VDO_REG_VS_BEG_LO:  o_reg_rdata <= vs_beg_r[7:0];
        `VDO_REG_VS_BEG_HI:  o_reg_rdata <= vs_beg_r[15:8];
        `VDO_REG_VS_END_LO:  o_reg_rdata <= vs_end_r[7:0];
        `VDO_REG_VS_END_HI:  o_reg_rdata <= vs_end_r[15:8];
        `VDO_REG_RANGE_CTRL: o_reg_rdata <= range_ctrl_r;
        `VDO_REG_DRIVE_EN:   o_reg_rdata <= drive_en_r;
        `VDO_REG_STATUS:     o_reg_rdata <= {o_locked, sig_r[1], field, 2'h0, std_r};
        default:             o_reg_rdata <= 8'h00;
      endcase
    end
  end
endmodule : vdo_output_ctrl

// File: design/vdo_consts.svh
// constants for the video decoder output control block
// Functional notes
// - reset autoswitch set excludes PAL-M, PAL-N, NTSC-4.43
// - enabled standards stay until hardware reset
// - detected standard reconfigures decoding without host writes
// - three 4:2:2 output formats selectable
// - raw 2x VBI or sliced VBI output
// - discrete syncs driven in embedded mode
// - all pixels output, active-video strobe crops; code blacks pixels outside the av_beg_r..av_end_r window
// - lock reached about twelve fields after input change
// - register 34h bits 4/0 enable data/clock
// - sync on luma for component SD only
// - no video: keep timing, output black
// - 2x samples decimated to pixel rate
// - output_code_range_control bit 6 selects coding range
// - vertical blanking carries data, horizontal blanking black
// - embedded mode masks horizontal blanking only
// - discrete mode masks horizontal and vertical blanking; code blacks only the vs_beg_r..vs_end_r lines of vertical blanking
// - component input bypasses filters, keeps decimation
// - fast-switch inputs select overlay sources
// - register 04h holds the autoswitch mask
`ifndef VDO_CONSTS_SVH
`define VDO_CONSTS_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define VDO_REG_INPUT_SEL   8'h00
`define VDO_REG_STD_MASK    8'h04
`define VDO_REG_FMT_CTRL    8'h0D
`define VDO_REG_AV_BEG_LO   8'h16
`define VDO_REG_AV_BEG_HI   8'h17
`define VDO_REG_AV_END_LO   8'h18
`define VDO_REG_AV_END_HI   8'h19
`define VDO_REG_VS_BEG_LO   8'h1A
`define VDO_REG_VS_BEG_HI   8'h1B
`define VDO_REG_VS_END_LO   8'h1C
`define VDO_REG_VS_END_HI   8'h1D
`define VDO_REG_RANGE_CTRL  8'h33
`define VDO_REG_DRIVE_EN    8'h34
`define VDO_REG_STATUS      8'h3A
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define VDO_BIT_EXT_RANGE   6
`define VDO_BIT_DATA_OE     4
`define VDO_BIT_CLK_OE      0
`define VDO_BIT_RAW_VBI     2
`define VDO_BIT_SLICED_VBI  3
`define VDO_BIT_FULL_FIELD  4
`define VDO_RST_STD_MASK    8'h07
`define VDO_RST_RANGE_CTRL  8'h40
`define VDO_RST_DRIVE_EN    8'h00
`define VDO_RST_AV_BEG      16'h007A
`define VDO_RST_AV_END      16'h034A
`define VDO_RST_VS_BEG      16'h0004
`define VDO_RST_VS_END      16'h0007
// ----------------------------------------
// timing counts
// ----------------------------------------
`define VDO_LOCK_FIELDS     4'hC
`define VDO_H_TOTAL_525     10'h35A
`define VDO_H_TOTAL_625     10'h360
`define VDO_H_ACT_BEG       10'h07A
`define VDO_H_ACT_END       10'h34A
`define VDO_HS_WIDTH        10'h040
`define VDO_LINES_525       10'h20D
`define VDO_LINES_625       10'h271
`define VDO_VBL_LINES_525   10'h014
`define VDO_VBL_LINES_625   10'h018
// ----------------------------------------
// codes
// ----------------------------------------
`define VDO_BLACK_Y         10'h040
`define VDO_BLACK_C         10'h200
`define VDO_EXT_MIN         10'h004
`define VDO_EXT_MAX         10'h3F8
`define VDO_STD_MIN         10'h040
`define VDO_STD_MAX_Y       10'h3AC
`define VDO_STD_MAX_C       10'h3C0
`define VDO_CODE_PRE        10'h3FF
`define VDO_CODE_ZERO       10'h000
`endif

// File: design/vdo_pkg.sv
// types shared by the video decoder output control block
package vdo_pkg;
  typedef enum logic [2:0] {
    VDO_STD_NTSC_M, VDO_STD_PAL_BDGHI, VDO_STD_SECAM,
    VDO_STD_PAL_M, VDO_STD_PAL_N, VDO_STD_NTSC_443
  } vdo_std_type;
  typedef enum logic [1:0] {
    VDO_FMT_EMBEDDED, VDO_FMT_DISCRETE, VDO_FMT_WIDE
  } vdo_fmt_type;
  typedef enum logic [1:0] {
    VDO_IN_COMPOSITE, VDO_IN_SEPARATE, VDO_IN_COMPONENT, VDO_IN_SCART
  } vdo_input_type;
  typedef struct packed {
    logic [9:0] luma;
    logic [9:0] chroma;
  } vdo_pixel_type;
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic field;
    logic active;
  } vdo_sync_type;
endpackage : vdo_pkg

// File: design/vdo_range_clamp.sv
// output coding range limiter for one channel
`timescale 1ns/1ps
module vdo_range_clamp #(
  parameter logic [9:0] STD_MAX = 10'h3AC
) (
  input  wire logic [9:0] i_data,
  input  wire logic       i_ext,
  output logic      [9:0] o_data
);
  `include "vdo_consts.svh"
  logic [9:0] lo;
  logic [9:0] hi;
  // extended range keeps overshoot, standard range clips to broadcast limits
  always_comb begin
    lo = i_ext ? `VDO_EXT_MIN : `VDO_STD_MIN;
    hi = i_ext ? `VDO_EXT_MAX : STD_MAX;
    if (i_data < lo) begin
      o_data = lo;
    end else if (i_data > hi) begin
      o_data = hi;
    end else begin
      o_data = i_data;
    end
  end
endmodule : vdo_range_clamp

// File: verif/vdo_output_ctrl_props.sv
// assertion checker for the output control block
`timescale 1ns/1ps
`include "vdo_consts.svh"
module vdo_output_ctrl_props
  import vdo_pkg::*;
(
  input wire logic          i_clk,
  input wire logic          i_rst,
  input wire logic [7:0]    i_reg_addr,
  input wire logic          i_reg_wr,
  input wire logic [7:0]    i_reg_wdata,
  input wire logic          i_std_detect,
  input wire vdo_std_type   i_std_code,
  input wire logic          i_signal_present,
  input wire vdo_std_type   o_active_std,
  input wire logic          o_locked,
  input wire logic          o_filter_bypass,
  input wire logic          o_sync_on_luma,
  input wire logic [19:0]   o_pixel_data,
  input wire vdo_sync_type  o_sync,
  input wire logic          o_pixel_clock_out,
  input wire logic          o_data_oe,
  input wire logic          o_clk_oe
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ----------------------------------------
  // helper state
  // ----------------------------------------
  logic [7:0]  mask_r;
  logic [14:0] hs_cnt_r;
  always_ff @(posedge i_clk) begin
    if (i_rst) mask_r <= `VDO_RST_STD_MASK;
    else if (i_reg_wr && i_reg_addr == `VDO_REG_STD_MASK) mask_r <= i_reg_wdata;
  end
  // one-bus lines take 1728 ticks of 8 cycles at most, so a longer gap means the timing stopped
  always_ff @(posedge i_clk) begin
    if (i_rst || $rose(o_sync.hsync)) hs_cnt_r <= 15'h0000;
    else hs_cnt_r <= hs_cnt_r + 15'h0001;
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  chk_drive_write: assert property (i_reg_wr && i_reg_addr == `VDO_REG_DRIVE_EN |=>
    o_data_oe == $past(i_reg_wdata[4]) && o_clk_oe == $past(i_reg_wdata[0])) else $error("drive enable mismatch");
  chk_clk_gate: assert property (!o_clk_oe |-> !o_pixel_clock_out) else $error("clock driven while off");
  chk_data_gate: assert property ((!o_data_oe)[*8] |=> o_pixel_data == 20'h0)
    else $error("data driven while off");
  chk_comp_pair: assert property (o_filter_bypass == o_sync_on_luma) else $error("bypass and luma sync differ");
  chk_masked_std: assert property (i_std_detect && !mask_r[i_std_code] |=> $stable(o_active_std))
    else $error("masked standard taken");
  chk_allowed_std: assert property (i_std_detect && mask_r[i_std_code] |=> o_active_std == $past(i_std_code))
    else $error("enabled standard not taken");
  chk_sync_edge: assert property ($changed(o_sync) && o_clk_oe |-> $rose(o_pixel_clock_out))
    else $error("sync moved off the clock edge");
  chk_pclk_rate: assert property ($rose(o_pixel_clock_out) && $past(o_clk_oe) |=>
    (!$rose(o_pixel_clock_out))[*5]) else $error("pixel clock too fast");
  chk_hsync_alive: assert property (hs_cnt_r < 15'h3800) else $error("hsync stopped");
  chk_nosig_unlock: assert property ((!i_signal_present)[*4] |-> !o_locked) else $error("locked without signal");
  chk_strobe_blank: assert property (o_sync.active |-> !o_sync.hsync) else $error("strobe inside hsync");
  cover property (o_sync.active && o_data_oe);
  cover property (i_std_detect && !mask_r[i_std_code]);
  cover property ($rose(o_sync.hsync) && o_clk_oe);
endmodule : vdo_output_ctrl_props

// File: verif/vdo_backend_model.sv
// backend model that counts strobed pixel words per line
`timescale 1ns/1ps
module vdo_backend_model
  import vdo_pkg::*;
(
  input  wire logic          i_clk,
  input  wire logic [19:0]   i_pixel_data,
  input  wire vdo_sync_type  i_sync,
  input  wire logic          i_pixel_clock_out,
  output logic      [11:0]   o_line_words
);
  logic        pclk_q = 1'b0;
  logic        hs_q   = 1'b0;
  logic [11:0] cnt_r  = 12'h000;
  // the pixel clock is oversampled here, so capture lands one system cycle after its rise
  always_ff @(posedge i_clk) begin
    pclk_q <= i_pixel_clock_out;
    if (i_pixel_clock_out && !pclk_q) begin
      hs_q <= i_sync.hsync;
      if (i_sync.hsync && !hs_q) begin
        o_line_words <= cnt_r;
        cnt_r        <= 12'h000;
      end else if (i_sync.active) begin
        cnt_r <= cnt_r + 12'h001;
      end
    end
  end
endmodule : vdo_backend_model

// File: verif/vdo_output_ctrl_tb.sv
// self-checking testbench for the output control block
`timescale 1ns/1ps
`include "vdo_consts.svh"
module vdo_output_ctrl_tb;
  import vdo_pkg::*;
  logic          i_clk = 0, i_rst = 1, i_reg_wr = 0, i_reg_rd = 0, i_line_clk = 0;
  logic          i_sample_valid = 0, i_std_detect = 0, i_signal_present = 1, i_slice_valid = 1;
  logic          i_overlay_fast_switch_in = 0, i_scart_fast_switch_in = 1;
  logic [7:0]    i_reg_addr = 0, i_reg_wdata = 0, o_reg_rdata, rv;
  vdo_pixel_type i_sample = 0, i_overlay_pixel = 0;
  vdo_std_type   i_std_code = VDO_STD_NTSC_M, o_active_std;
  logic [9:0]    i_slice_data = 0, lo, hy, hc, p1, p2;
  logic          o_locked, o_filter_bypass, o_sync_on_luma, o_scart_rgb_sel, o_pixel_clock_out;
  logic          o_data_oe, o_clk_oe, found;
  logic [19:0]   o_pixel_data;
  vdo_sync_type  o_sync;
  logic [11:0]   line_words;
  logic [15:0]   beg, fin;
  logic [2:0]    cur;
  logic [31:0]   seed = 32'h9BB334C6;
  int            mismatches = 0, tests_run = 0;
  logic [7:0]    ra [8] = '{8'h04, 8'h33, 8'h34, 8'h16, 8'h17, 8'h18, 8'h19, 8'hFF};
  logic [7:0]    re [8] = '{8'h07, 8'h40, 8'h00, 8'h7A, 8'h00, 8'h4A, 8'h03, 8'h00};
  logic [2:0]    codes [6] = '{3'h1, 3'h3, 3'h2, 3'h4, 3'h5, 3'h0};

  vdo_output_ctrl dut_u (.*);
  vdo_backend_model bk_u (.i_clk, .i_pixel_data(o_pixel_data), .i_sync(o_sync),
                          .i_pixel_clock_out(o_pixel_clock_out), .o_line_words(line_words));
  // ----------------------------------------
  // clocks and random stimulus
  // ----------------------------------------
  initial forever #5 i_clk = ~i_clk;
  initial begin
    #3;
    forever #40 i_line_clk = ~i_line_clk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  always @(negedge i_clk) begin
    seed            <= lfsr(seed);
    i_sample        <= seed[19:0];
    i_overlay_pixel <= ~seed[19:0];
    i_slice_data    <= seed[29:20];
    i_sample_valid  <= seed[1:0] == 2'h0;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  function automatic logic [2:0] exp_std(input logic [2:0] c, n, input logic [7:0] m);
    return m[n] ? n : c;
  endfunction : exp_std
  task automatic check(input logic [19:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, d);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1;
    @(negedge i_clk);
    i_reg_wr = 0;
  endtask : wr
  task automatic rchk(input logic [7:0] a, e);
    @(negedge i_clk);
    i_reg_addr = a;
    i_reg_rd = 1;
    @(negedge i_clk);
    i_reg_rd = 0;
    @(negedge i_clk);
    check(o_reg_rdata, e, "register read");
  endtask : rchk
  task automatic tick();
    @(posedge o_pixel_clock_out);
    @(negedge i_clk);
  endtask : tick
  task automatic detect_all(input logic [7:0] m);
    foreach (codes[k]) begin
      @(negedge i_clk);
      i_std_code = vdo_std_type'(codes[k]);
      i_std_detect = 1;
      @(negedge i_clk);
      i_std_detect = 0;
      cur = exp_std(cur, codes[k], m);
      @(negedge i_clk);
      check(o_active_std, cur, "active standard");
    end
  endtask : detect_all
  task automatic print_verdict;
    $display("Checks run %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // run is about 50k cycles; 90k means a hang
  initial begin
    #900000;
    mismatches++;
    print_verdict;
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (12) @(negedge i_clk);
    i_rst = 0;
    repeat (20) @(negedge i_clk);
    check({o_data_oe, o_clk_oe, o_pixel_clock_out}, 0, "outputs off after reset");
    foreach (ra[k]) rchk(ra[k], re[k]);
    cur = 3'h0;
    detect_all(8'h07);
    wr(`VDO_REG_STD_MASK, 8'h3F);
    detect_all(8'h3F);
    for (int k = 0; k < 4; k++) begin
      wr(`VDO_REG_INPUT_SEL, k[7:0]);
      repeat (4) @(negedge i_clk);
      check({o_filter_bypass, o_sync_on_luma, o_scart_rgb_sel}, {k == 2, k == 2, k == 3}, "input path");
    end
    wr(`VDO_REG_DRIVE_EN, 8'h11);
    check({o_data_oe, o_clk_oe}, 2'b11, "outputs on");
    wr(`VDO_REG_FMT_CTRL, 8'h0A);
    for (int e = 1; e >= 0; e--) begin
      wr(`VDO_REG_RANGE_CTRL, e ? 8'h40 : 8'h00);
      i_overlay_fast_switch_in = e == 0;
      lo = e ? 10'h004 : 10'h040;
      hy = e ? 10'h3F8 : 10'h3AC;
      hc = e ? 10'h3F8 : 10'h3C0;
      repeat (2) tick();
      repeat (200) begin
        tick();
        check(o_pixel_data[19:10] >= lo && o_pixel_data[19:10] <= hy, 1, "luma range");
        check(o_pixel_data[9:0] >= lo && o_pixel_data[9:0] <= hc, 1, "chroma range");
        if (o_sync.hsync) check(o_pixel_data, 20'h10200, "hblank black");
      end
    end
    beg = 16'h0080 + seed[5:0];
    fin = 16'h0300 - seed[13:8];
    wr(`VDO_REG_AV_BEG_LO, beg[7:0]);
    wr(`VDO_REG_AV_BEG_HI, beg[15:8]);
    wr(`VDO_REG_AV_END_LO, fin[7:0]);
    wr(`VDO_REG_AV_END_HI, fin[15:8]);
    repeat (3) @(posedge o_sync.hsync);
    repeat (4) @(negedge i_clk);
    check(line_words, fin - beg, "strobed words per line");
    i_signal_present = 0;
    repeat (50) @(negedge i_clk);
    check(o_locked, 0, "lock without signal");
    repeat (100) begin
      tick();
      check(o_pixel_data, 20'h10200, "no signal black");
    end
    i_signal_present = 1;
    for (int f = 0; f < 2; f++) begin
      wr(`VDO_REG_FMT_CTRL, f[7:0]);
      found = 0;
      p1 = 10'h3FF;
      p2 = 10'h3FF;
      repeat (2) tick();
      repeat (1800) begin
        tick();
        check(o_pixel_data[19:10], 0, "upper bus idle");
        if (p2 == 10'h3FF && p1 == 10'h000 && o_pixel_data[9:0] == 10'h000) found = 1;
        p2 = p1;
        p1 = o_pixel_data[9:0];
      end
      check(found, f == 0, "timing reference words");
    end
    wr(`VDO_REG_DRIVE_EN, 8'h01);
    repeat (12) @(negedge i_clk);
    check({o_pixel_data, o_data_oe, o_clk_oe}, 22'h1, "data off clock on");
    i_rst = 1;
    repeat (12) @(negedge i_clk);
    i_rst = 0;
    rchk(`VDO_REG_STD_MASK, 8'h07);
    check({o_data_oe, o_clk_oe}, 0, "outputs off again");
    print_verdict;
  end
endmodule : vdo_output_ctrl_tb
bind vdo_output_ctrl vdo_output_ctrl_props chk_u (.*);
